// ===== rtl/function_block.sv
// configurable function block: timer, totalizer, comparator, sequencer
`timescale 1ns/1ps
`include "fb_cfg.svh"
module function_block (
  input wire logic CLOCK_IN,
  input wire logic RST_IN,
  input wire logic TICK_IN,
  input wire logic [7:0] ADDR_IN,
  input wire logic [31:0] WR_DATA_IN,
  input wire logic WR_STB_IN,
  input wire logic RD_STB_IN,
  output logic [31:0] RD_DATA_OUT,
  input wire logic [7:0] LOGIC_IN,
  input wire logic [7:0] RESET_CH_IN,
  input wire logic [7:0][15:0] ANALOG_IN,
  input wire logic [7:0][15:0] SETPOINT_IN,
  input wire logic [15:0] DEMAND_IN,
  input wire logic RAISE_IN,
  input wire logic LOWER_IN,
  input wire logic [7:0] DISABLE_IN,
  input wire logic [23:0] CASCADE_IN,
  output logic [23:0] CASCADE_OUT,
  output logic [7:0] LOGIC_OUT,
  output logic [7:0][23:0] NUMERIC_OUT,
  output logic [24:0] SEQ_DIFF_OUT
);
  import fb_pkg::*;

  // ****************************************
  // configuration registers
  // ****************************************
  fb_mode_type mode_q;
  logic [7:0] hold_q;
  logic [7:0] panel_q;
  logic [7:0] cfg_q [8];
  logic [23:0] pa_q [8];
  logic [23:0] pb_q [8];
  logic [15:0] lf_q [8];
  logic [7:0] seq_cfg_q;
  logic [23:0] seq_delay_q;
  logic [15:0] seq_step_q;
  logic [31:0] rd_data_q;

  logic [4:0] grp;
  logic [2:0] idx;
  logic numeric_wr;

  assign grp = ADDR_IN[7:3];
  assign idx = ADDR_IN[2:0];
  assign numeric_wr = WR_STB_IN && grp == `GRP_NUMERIC;

  always_ff @(posedge CLOCK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      mode_q <= MODE_TIMER;
      hold_q <= 8'h00;
      panel_q <= 8'h00;
      seq_cfg_q <= {4'h0, `SEQ_COUNT_RST};
      seq_delay_q <= 24'h0;
      seq_step_q <= 16'h0;
      for (int i = 0; i < 8; i++) begin
        cfg_q[i] <= 8'h00;
        pa_q[i] <= 24'h0;
        pb_q[i] <= 24'h0;
        lf_q[i] <= 16'h0;
      end
    end else if (WR_STB_IN) begin
      case (grp)
        `GRP_SINGLE: begin
          case (ADDR_IN)
            `ADDR_MODE: mode_q <= fb_mode_type'(WR_DATA_IN[3:0]);
            `ADDR_HOLD: hold_q <= WR_DATA_IN[7:0];
            `ADDR_PANEL: panel_q <= WR_DATA_IN[7:0]; // [R08]
            `ADDR_SEQ_CFG: seq_cfg_q <= WR_DATA_IN[7:0];
            `ADDR_SEQ_DELAY: seq_delay_q <= WR_DATA_IN[23:0];
            `ADDR_SEQ_STEP: seq_step_q <= WR_DATA_IN[15:0];
            default: ;
          endcase
        end
        `GRP_CFG: cfg_q[idx] <= WR_DATA_IN[7:0];
        `GRP_PARAM_A: pa_q[idx] <= WR_DATA_IN[23:0];
        `GRP_PARAM_B: pb_q[idx] <= WR_DATA_IN[23:0];
        `GRP_LOAD: lf_q[idx] <= WR_DATA_IN[15:0];
        default: ;
      endcase
    end
  end

  // ****************************************
  // timer and totalizer channels
  // ****************************************
  logic [7:0] tmr_out;
  logic [7:0] tot_flag;
  logic [23:0] tot_val [8];
  logic [23:0] tot_acc [8];

  for (genvar g = 0; g < 8; g++) begin : g_ch
    delay_channel u_delay (
      .clk_in(CLOCK_IN),
      .rst_in(RST_IN),
      .tick_in(TICK_IN),
      .func_in(timer_func_type'(cfg_q[g][`CFG_FUNC_MSB:`CFG_FUNC_LSB])),
      .period_in(pa_q[g]),
      .trig_in(LOGIC_IN[g]), // [R01]
      .clear_in(RESET_CH_IN[g]),
      .out_out(tmr_out[g])
    );
    totalizer_channel u_total (
      .clk_in(CLOCK_IN),
      .rst_in(RST_IN),
      .tick_in(TICK_IN),
      .func_in(total_func_type'(cfg_q[g][`CFG_FUNC_MSB:`CFG_FUNC_LSB])),
      .limit_in(pa_q[g]),
      .rate_in(pb_q[g]),
      .roll_in(cfg_q[g][`CFG_ROLL_BIT]),
      .acc15_in(cfg_q[g][`CFG_ACC15_BIT]),
      .event_in(LOGIC_IN[g]), // [R09]
      .analog_in(ANALOG_IN[g]),
      .clear_in(RESET_CH_IN[g]),
      .hold_in(hold_q[g]),
      .load_in(numeric_wr && idx == g && mode_q == MODE_TOTAL),
      .load_val_in(WR_DATA_IN[23:0]),
      .total_out(tot_val[g]),
      .flag_out(tot_flag[g]),
      .acc_out(tot_acc[g])
    );
  end

  // ****************************************
  // comparator
  // ****************************************
  logic [7:0] cmp_q;
  logic [16:0] dev_q [8];
  logic signed [15:0] sp [8];
  logic signed [16:0] dev [8];

  always_comb begin
    for (int i = 0; i < 8; i++) begin
      sp[i] = cfg_q[i][`CFG_SPVAR_BIT] ? signed'(SETPOINT_IN[i])
                                      : signed'(pa_q[i][15:0]); // [R17]
      dev[i] = 17'(signed'(ANALOG_IN[i])) - 17'(sp[i]); // [R17]
    end
  end

  always_ff @(posedge CLOCK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      cmp_q <= 8'h00;
      for (int i = 0; i < 8; i++) begin
        dev_q[i] <= 17'h0;
      end
    end else begin
      for (int i = 0; i < 8; i++) begin
        if (numeric_wr && idx == i && hold_q[i]) begin
          dev_q[i] <= WR_DATA_IN[16:0]; // [R08]
        end else if (TICK_IN && !hold_q[i]) begin
          dev_q[i] <= dev[i];
          cmp_q[i] <= cfg_q[i][`CFG_BELOW_BIT] ? dev[i] < 0
                                              : dev[i] > 0; // [R16]
        end
      end
    end
  end

  // ****************************************
  // sequencer
  // ****************************************
  logic [7:0] stage_q;
  logic [23:0] req_q;
  logic [23:0] wait_q;
  logic [3:0] count;
  logic [7:0] in_use;
  logic [23:0] cap;
  logic [23:0] act;
  logic [23:0] req_an;
  logic [39:0] prod;
  logic [15:0] pct;
  logic [2:0] on_idx;
  logic [2:0] off_idx;
  logic on_found;
  logic off_found;
  logic [7:0] dropped;
  logic [24:0] ramp_up;

  assign count = seq_cfg_q[`SEQ_COUNT_MSB:`SEQ_COUNT_LSB];
  assign pct = (DEMAND_IN > `PERCENT_FULL) ? `PERCENT_FULL : DEMAND_IN;
  assign prod = {24'h0, pct} * {16'h0, cap};
  assign req_an = 24'(prod / 40'd100); // [R20]
  assign ramp_up = {1'b0, req_q} + {9'h0, seq_step_q};
  assign dropped = stage_q & DISABLE_IN;

  always_comb begin
    cap = 24'h0;
    act = 24'h0;
    in_use = 8'h00;
    on_idx = 3'h0;
    off_idx = 3'h0;
    on_found = 1'b0;
    off_found = 1'b0;
    for (int i = 7; i >= 0; i--) begin
      in_use[i] = (4'(i) < count); // [R18]
      if (in_use[i]) begin
        cap = cap + {8'h00, lf_q[i]};
        if (stage_q[i]) begin
          act = act + {8'h00, lf_q[i]}; // [R21]
        end
        if (!stage_q[i] && !DISABLE_IN[i]) begin
          on_idx = 3'(i);
          on_found = 1'b1;
        end
      end
    end
    for (int i = 0; i < 8; i++) begin
      if (stage_q[i]) begin
        off_idx = 3'(i);
        off_found = 1'b1;
      end
    end
  end

  // demand: analog percent, raise/lower ramp, or residue of a prior block
  always_ff @(posedge CLOCK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      req_q <= 24'h0;
    end else if (TICK_IN) begin
      if (seq_cfg_q[`SEQ_LINK_BIT]) begin
        req_q <= CASCADE_IN; // [R19]
      end else if (!seq_cfg_q[`SEQ_LOGIC_BIT]) begin
        req_q <= req_an; // [R20]
      end else if (RAISE_IN && !LOWER_IN) begin
        req_q <= (ramp_up > {1'b0, cap}) ? cap : ramp_up[23:0]; // [R20]
      end else if (LOWER_IN && !RAISE_IN) begin
        req_q <= (req_q > {8'h00, seq_step_q}) ?
                 req_q - {8'h00, seq_step_q} : 24'h0; // [R20]
      end
    end
  end

  // one stage per step, last on first off, then a blocking delay
  always_ff @(posedge CLOCK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      stage_q <= 8'h00;
      wait_q <= 24'h0;
    end else if (mode_q != MODE_SEQUENCE) begin
      stage_q <= 8'h00;
      wait_q <= 24'h0;
    end else if (TICK_IN) begin
      if (dropped != 8'h00 || (stage_q & ~in_use) != 8'h00) begin
        stage_q <= stage_q & ~DISABLE_IN & in_use; // [R18]
        wait_q <= seq_delay_q; // [R21]
      end else if (wait_q != 24'h0) begin
        wait_q <= wait_q - 24'h1; // [R21]
      end else if (act < req_q && on_found) begin
        stage_q[on_idx] <= 1'b1; // [R21]
        wait_q <= seq_delay_q;
      end else if (off_found && act - {8'h00, lf_q[off_idx]} >= req_q
                   && act > req_q) begin
        stage_q[off_idx] <= 1'b0; // [R21]
        wait_q <= seq_delay_q;
      end
    end
  end

  // ****************************************
  // outputs and read port
  // ****************************************
  logic [7:0] logic_q;
  logic [23:0] num_q [8];
  logic [24:0] diff_q;
  logic [23:0] casc_q;
  logic [7:0] alg;

  always_comb begin
    case (mode_q)
      MODE_TIMER: alg = tmr_out;
      MODE_TOTAL: alg = tot_flag;
      MODE_COMPARE: alg = cmp_q;
      MODE_SEQUENCE: alg = stage_q;
      default: alg = 8'h00;
    endcase
  end

  always_ff @(posedge CLOCK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      logic_q <= 8'h00;
      diff_q <= 25'h0;
      casc_q <= 24'h0;
      for (int i = 0; i < 8; i++) begin
        num_q[i] <= 24'h0;
      end
    end else begin
      logic_q <= (hold_q & panel_q) | (~hold_q & alg); // [R08]
      diff_q <= {1'b0, req_q} - {1'b0, act}; // [R22]
      casc_q <= (req_q > cap) ? req_q - cap : 24'h0; // [R19]
      for (int i = 0; i < 8; i++) begin
        case (mode_q)
          MODE_TOTAL: num_q[i] <= tot_val[i];
          MODE_COMPARE: num_q[i] <= {{7{dev_q[i][16]}}, dev_q[i]};
          default: num_q[i] <= 24'h0;
        endcase
      end
    end
  end

  always_ff @(posedge CLOCK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      rd_data_q <= 32'h0;
    end else if (RD_STB_IN) begin
      case (grp)
        `GRP_SINGLE: begin
          case (ADDR_IN)
            `ADDR_MODE: rd_data_q <= {28'h0, mode_q};
            `ADDR_HOLD: rd_data_q <= {24'h0, hold_q};
            `ADDR_PANEL: rd_data_q <= {24'h0, panel_q};
            `ADDR_LOGIC: rd_data_q <= {24'h0, logic_q};
            `ADDR_SEQ_CFG: rd_data_q <= {24'h0, seq_cfg_q};
            `ADDR_SEQ_DELAY: rd_data_q <= {8'h00, seq_delay_q};
            `ADDR_SEQ_STEP: rd_data_q <= {16'h0, seq_step_q};
            `ADDR_SEQ_DIFF: rd_data_q <= {{7{diff_q[24]}}, diff_q};
            default: rd_data_q <= 32'h0;
          endcase
        end
        `GRP_SEQ_STAGES: rd_data_q <= {24'h0, stage_q};
        `GRP_CFG: rd_data_q <= {24'h0, cfg_q[idx]};
        `GRP_PARAM_A: rd_data_q <= {8'h00, pa_q[idx]};
        `GRP_PARAM_B: rd_data_q <= {8'h00, pb_q[idx]};
        `GRP_NUMERIC: rd_data_q <= {8'h00, num_q[idx]};
        `GRP_ACC: rd_data_q <= {8'h00, tot_acc[idx]};
        `GRP_LOAD: rd_data_q <= {16'h0, lf_q[idx]};
        default: rd_data_q <= 32'h0;
      endcase
    end else begin
      rd_data_q <= 32'h0;
    end
  end

  assign RD_DATA_OUT = rd_data_q;
  assign LOGIC_OUT = logic_q;
  assign SEQ_DIFF_OUT = diff_q;
  assign CASCADE_OUT = casc_q;
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      NUMERIC_OUT[i] = num_q[i];
    end
  end
endmodule

// ===== rtl/fb_cfg.svh
// register map, field positions and limits of the function block
//
// Summary of operation
// [R01] timer mode: eight delay channels, trigger, reset
// [R02] pulse: rising edge gives T high, ignore retriggers
// [R03] reset input forces output low, aborts timing
// [R04] retriggerable pulse restarts T on each edge
// [R05] latching on-delay: high after T, held till reset
// [R06] on-delay: high after T, falls with input
// [R07] off-delay: rises with input, falls T later
// [R08] hold freezes output; panel may write it
// [R09] totalizer: eight channels, three selectable functions
// [R10] total value plus full scale flag
// [R11] accumulator counts limit hits, two maxima
// [R12] event counter scales rising edges, reset clears
// [R13] at limit saturate with flag, or roll over
// [R14] integrator adds input at time-constant rate
// [R15] on-time counter grows while input high
// [R16] comparator status above or below setpoint
// [R17] comparator numeric output is the deviation
// [R18] sequencer drives stages from demand, disables
// [R19] two sequencers chain for sixteen stages
// [R20] analog demand percent, or raise/lower inputs
// [R21] load-weighted staging with switching delay timer
// [R22] sequencer outputs requested minus active output
// [R23] everything paced by the execution tick; bus writes and the stage clear outside sequence mode act on any clock
`ifndef FB_CFG_SVH
`define FB_CFG_SVH

// single registers (group 0, word addresses)
`define ADDR_MODE 8'h00
`define ADDR_HOLD 8'h01
`define ADDR_PANEL 8'h02
`define ADDR_LOGIC 8'h03
`define ADDR_SEQ_CFG 8'h04
`define ADDR_SEQ_DELAY 8'h05
`define ADDR_SEQ_STEP 8'h06
`define ADDR_SEQ_DIFF 8'h07
// per-channel groups, index in address bits 2:0
`define GRP_SINGLE 5'h00
`define GRP_SEQ_STAGES 5'h01
`define GRP_CFG 5'h02
`define GRP_PARAM_A 5'h03
`define GRP_PARAM_B 5'h04
`define GRP_NUMERIC 5'h05
`define GRP_ACC 5'h06
`define GRP_LOAD 5'h07

// channel configuration fields
`define CFG_FUNC_LSB 0
`define CFG_FUNC_MSB 2
`define CFG_ROLL_BIT 3
`define CFG_ACC15_BIT 4
`define CFG_BELOW_BIT 5
`define CFG_SPVAR_BIT 6
// sequencer configuration fields
`define SEQ_COUNT_LSB 0
`define SEQ_COUNT_MSB 3
`define SEQ_LINK_BIT 4
`define SEQ_LOGIC_BIT 5

`define ACC_MAX_DEC 24'd9999999
`define ACC_MAX_15B 24'd32767
`define PERCENT_FULL 16'd100
`define SEQ_COUNT_RST 4'h8

`endif

// ===== rtl/fb_pkg.sv
// types shared by the function block modules
package fb_pkg;
  typedef enum logic [3:0] {
    MODE_TIMER = 4'h1,
    MODE_TOTAL = 4'h2,
    MODE_COMPARE = 4'h4,
    MODE_SEQUENCE = 4'h8
  } fb_mode_type;

  typedef enum logic [2:0] {
    TF_PULSE = 3'h0,
    TF_RETRIG = 3'h1,
    TF_ON_MEM = 3'h2,
    TF_ON_DELAY = 3'h3,
    TF_OFF_DELAY = 3'h4
  } timer_func_type;

  typedef enum logic [2:0] {
    TOT_EVENT = 3'h0,
    TOT_INTEG = 3'h1,
    TOT_ONTIME = 3'h2
  } total_func_type;
endpackage

// ===== rtl/delay_channel.sv
// one time delay channel of the timer mode
`timescale 1ns/1ps
module delay_channel (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic tick_in,
  input wire fb_pkg::timer_func_type func_in,
  input wire logic [23:0] period_in,
  input wire logic trig_in,
  input wire logic clear_in,
  output logic out_out
);
  import fb_pkg::*;
  logic [23:0] left_q;
  logic prev_q;
  logic out_q;
  logic rise;
  logic [23:0] per;

  // a zero period would never time out, so it acts as one tick
  assign per = (period_in == 24'h0) ? 24'h1 : period_in;
  assign rise = trig_in & ~prev_q;
  assign out_out = out_q;

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      prev_q <= 1'b0;
    end else if (tick_in) begin
      prev_q <= trig_in; // [R23]
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      left_q <= 24'h0;
      out_q <= 1'b0;
    end else if (tick_in) begin
      if (clear_in) begin
        left_q <= 24'h0; // [R03]
        out_q <= 1'b0; // [R03]
      end else begin
        case (func_in)
          TF_PULSE, TF_RETRIG: begin
            if (rise && (!out_q || func_in == TF_RETRIG)) begin
              out_q <= 1'b1; // [R02] [R04]
              left_q <= per; // [R04]
            end else if (left_q != 24'h0) begin
              left_q <= left_q - 24'h1;
              if (left_q == 24'h1) begin
                out_q <= 1'b0; // [R02]
              end
            end
          end
          TF_ON_MEM, TF_ON_DELAY: begin
            if (trig_in) begin
              if (left_q != per) begin
                left_q <= left_q + 24'h1;
              end
              if (left_q + 24'h1 >= per) begin
                out_q <= 1'b1; // [R05] [R06]
              end
            end else begin
              left_q <= 24'h0; // [R05]
              if (func_in == TF_ON_DELAY) begin
                out_q <= 1'b0; // [R06]
              end
            end
          end
          TF_OFF_DELAY: begin
            if (trig_in) begin
              out_q <= 1'b1; // [R07]
              left_q <= per;
            end else if (left_q != 24'h0) begin
              left_q <= left_q - 24'h1;
              if (left_q == 24'h1) begin
                out_q <= 1'b0; // [R07]
              end
            end
          end
          default: begin
            left_q <= 24'h0;
            out_q <= 1'b0;
          end
        endcase
      end
    end
  end
endmodule

// ===== rtl/totalizer_channel.sv
// one totalizer channel: event count, integration or on-time
`timescale 1ns/1ps
`include "fb_cfg.svh"
module totalizer_channel (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic tick_in,
  input wire fb_pkg::total_func_type func_in,
  input wire logic [23:0] limit_in,
  input wire logic [23:0] rate_in,
  input wire logic roll_in,
  input wire logic acc15_in,
  input wire logic event_in,
  input wire logic [15:0] analog_in,
  input wire logic clear_in,
  input wire logic hold_in,
  input wire logic load_in,
  input wire logic [23:0] load_val_in,
  output logic [23:0] total_out,
  output logic flag_out,
  output logic [23:0] acc_out
);
  import fb_pkg::*;
  logic [23:0] total_q;
  logic flag_q;
  logic [23:0] acc_q;
  logic [23:0] pre_q;
  logic prev_q;
  logic [23:0] inc;
  logic [24:0] sum;
  logic [23:0] acc_max;

  assign total_out = total_q;
  assign flag_out = flag_q;
  assign acc_out = acc_q;
  assign acc_max = acc15_in ? `ACC_MAX_15B : `ACC_MAX_DEC; // [R11]

  always_comb begin
    inc = 24'h0;
    case (func_in)
      TOT_EVENT: begin
        if (event_in && !prev_q) begin
          inc = rate_in; // [R12]
        end
      end
      // negative samples are ignored; the total only grows
      TOT_INTEG: begin
        if (pre_q == 24'h0 && !analog_in[15]) begin
          inc = {8'h00, analog_in}; // [R14]
        end
      end
      TOT_ONTIME: begin
        if (pre_q == 24'h0 && event_in) begin
          inc = 24'h1; // [R15]
        end
      end
      default: inc = 24'h0;
    endcase
    sum = {1'b0, total_q} + {1'b0, inc};
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      pre_q <= 24'h0;
      prev_q <= 1'b0;
    end else if (tick_in) begin
      prev_q <= event_in;
      if (pre_q == 24'h0) begin
        pre_q <= (rate_in == 24'h0) ? 24'h0 : rate_in - 24'h1; // [R23]
      end else begin
        pre_q <= pre_q - 24'h1;
      end
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      total_q <= 24'h0;
      flag_q <= 1'b0;
      acc_q <= 24'h0;
    end else if (load_in && hold_in) begin
      total_q <= load_val_in; // [R08]
    end else if (tick_in && !hold_in) begin
      if (clear_in) begin
        total_q <= 24'h0; // [R12] [R14] [R15]
        flag_q <= 1'b0;
      end else if (!flag_q && sum >= {1'b0, limit_in}) begin
        if (roll_in) begin
          total_q <= 24'h0; // [R13]
          if (acc_q < acc_max) begin
            acc_q <= acc_q + 24'h1; // [R11]
          end
        end else begin
          total_q <= limit_in; // [R13]
          flag_q <= 1'b1; // [R10]
        end
      end else if (!flag_q) begin
        total_q <= sum[23:0];
      end
    end
  end
endmodule

// ===== dv/tick_source.sv
// execution strobe source standing in for the controller scan
`timescale 1ns/1ps
module tick_source #(
  parameter int PERIOD = 4
) (
  input wire logic clk_in,
  input wire logic rst_in,
  output logic tick_out
);
  // ****
  // strobe generator
  // ****
  logic [7:0] count_q;
  // one-cycle strobe every PERIOD clocks paces all channel work
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      count_q <= 8'h00;
      tick_out <= 1'b0;
    end else begin
      count_q <= (count_q == 8'(PERIOD - 1)) ? 8'h00 : count_q + 8'h01;
      tick_out <= (count_q == 8'(PERIOD - 1));
    end
  end
endmodule

// ===== dv/function_block_assertions.sv
// port-level assertions for the function block
`timescale 1ns/1ps
`include "fb_cfg.svh"
module function_block_check (
  input wire logic CLOCK_IN,
  input wire logic RST_IN,
  input wire logic TICK_IN,
  input wire logic [7:0] ADDR_IN,
  input wire logic [31:0] WR_DATA_IN,
  input wire logic WR_STB_IN,
  input wire logic RD_STB_IN,
  input wire logic [31:0] RD_DATA_OUT,
  input wire logic [7:0] LOGIC_OUT,
  input wire logic [7:0][23:0] NUMERIC_OUT
);
  // ****
  // mirror of hold, panel and mode registers
  // ****
  logic [7:0] hold_q;
  logic [7:0] panel_q;
  logic [3:0] mode_q;
  always_ff @(posedge CLOCK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      hold_q <= 8'h00;
      panel_q <= 8'h00;
      mode_q <= 4'h1;
    end else if (WR_STB_IN) begin
      if (ADDR_IN == `ADDR_HOLD) hold_q <= WR_DATA_IN[7:0];
      if (ADDR_IN == `ADDR_PANEL) panel_q <= WR_DATA_IN[7:0];
      if (ADDR_IN == `ADDR_MODE) mode_q <= WR_DATA_IN[3:0];
    end
  end
  default clocking cb @(posedge CLOCK_IN); endclocking
  default disable iff (RST_IN);
  // ****
  // properties
  // ****
  chk_read_idle: assert property (RD_DATA_OUT != 32'h0 |-> $past(RD_STB_IN))
    else $error("read data outside a read slot");
  chk_unmapped_read: assert property (
    RD_STB_IN && ADDR_IN[7:6] != 2'h0 |=> RD_DATA_OUT == 32'h0)
    else $error("unmapped read returned data");
  chk_hold_readback: assert property (
    WR_STB_IN && ADDR_IN == `ADDR_HOLD ##1 RD_STB_IN && ADDR_IN == `ADDR_HOLD
    |=> RD_DATA_OUT == {24'h0, hold_q})
    else $error("hold register readback wrong");
  chk_reset_zero: assert property ($fell(RST_IN) |->
    LOGIC_OUT == 8'h00 && NUMERIC_OUT == '0 && RD_DATA_OUT == 32'h0)
    else $error("outputs not zero after reset");
  chk_numeric_tick: assert property (
    !$past(TICK_IN, 2) && !$past(WR_STB_IN) && !$past(WR_STB_IN, 2)
    |-> $stable(NUMERIC_OUT))
    else $error("numeric output moved without a tick");
  chk_timer_tick: assert property (
    mode_q == 4'h1 && !$past(TICK_IN, 2) && !$past(WR_STB_IN)
    && !$past(WR_STB_IN, 2) |-> $stable(LOGIC_OUT))
    else $error("timer output moved without a tick");
  chk_held_panel: assert property (
    $stable(hold_q) && $stable(panel_q)
    |-> (LOGIC_OUT & hold_q) == (panel_q & hold_q))
    else $error("held channel not showing panel value");
  chk_numeric_idle: assert property (
    (mode_q == 4'h1 || mode_q == 4'h8) && $stable(mode_q)
    |=> NUMERIC_OUT == '0)
    else $error("numeric output nonzero in timer or sequencer mode");
endmodule
bind function_block function_block_check i_chk (
  .CLOCK_IN(CLOCK_IN), .RST_IN(RST_IN), .TICK_IN(TICK_IN),
  .ADDR_IN(ADDR_IN), .WR_DATA_IN(WR_DATA_IN), .WR_STB_IN(WR_STB_IN),
  .RD_STB_IN(RD_STB_IN), .RD_DATA_OUT(RD_DATA_OUT),
  .LOGIC_OUT(LOGIC_OUT), .NUMERIC_OUT(NUMERIC_OUT));

// ===== dv/tb_top.sv
// self-checking bench for the function block
`timescale 1ns/1ps
`include "fb_cfg.svh"
module tb_top;
  import fb_pkg::*;
  logic CLOCK_IN = 1'b0;
  logic RST_IN = 1'b1;
  logic TICK_IN;
  logic [7:0] ADDR_IN = 8'h00;
  logic [31:0] WR_DATA_IN = 32'h0;
  logic WR_STB_IN = 1'b0;
  logic RD_STB_IN = 1'b0;
  logic [31:0] RD_DATA_OUT;
  logic [7:0] LOGIC_IN = 8'h00;
  logic [7:0] RESET_CH_IN = 8'h00;
  logic [7:0][15:0] ANALOG_IN = '0;
  logic [7:0][15:0] SETPOINT_IN = '0;
  logic [15:0] DEMAND_IN = 16'h0;
  logic [7:0] DISABLE_IN = 8'h00;
  logic [23:0] CASCADE_OUT;
  logic [7:0] LOGIC_OUT;
  logic [7:0][23:0] NUMERIC_OUT;
  logic [24:0] SEQ_DIFF_OUT;
  int fails = 0;
  int check_count = 0;
  int cycles = 0;
  // ****
  // per-tick stimulus and expectation, bit n is tick n
  // ****
  localparam logic [11:0] tin_tab [8] = '{12'hFDD, 12'hEF5, 12'hC3B,
    12'hF6F, 12'h143, 12'hFDD, 12'hFDD, 12'h000};
  localparam logic [11:0] rst_tab [8] = '{12'h080, 12'h400, 12'h100,
    12'h800, 12'h000, 12'h000, 12'h000, 12'h000};
  localparam logic [11:0] exp_tab [8] = '{12'h047, 12'h27F, 12'h0E0,
    12'h40C, 12'h7CF, 12'hFFF, 12'h000, 12'h000};

  always #12.5 CLOCK_IN = ~CLOCK_IN;

  tick_source #(.PERIOD(4)) i_tick (.clk_in(CLOCK_IN), .rst_in(RST_IN),
    .tick_out(TICK_IN));

  function_block i_dut (.CLOCK_IN(CLOCK_IN), .RST_IN(RST_IN),
    .TICK_IN(TICK_IN), .ADDR_IN(ADDR_IN), .WR_DATA_IN(WR_DATA_IN),
    .WR_STB_IN(WR_STB_IN), .RD_STB_IN(RD_STB_IN), .RD_DATA_OUT(RD_DATA_OUT),
    .LOGIC_IN(LOGIC_IN), .RESET_CH_IN(RESET_CH_IN), .ANALOG_IN(ANALOG_IN),
    .SETPOINT_IN(SETPOINT_IN), .DEMAND_IN(DEMAND_IN), .RAISE_IN(1'b0),
    .LOWER_IN(1'b0), .DISABLE_IN(DISABLE_IN), .CASCADE_IN(24'h0),
    .CASCADE_OUT(CASCADE_OUT), .LOGIC_OUT(LOGIC_OUT),
    .NUMERIC_OUT(NUMERIC_OUT), .SEQ_DIFF_OUT(SEQ_DIFF_OUT));

  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    check_count++;
    if (seen !== want) begin
      fails++;
      $display("MISMATCH %0t seen %h want %h", $time, seen, want);
    end
  endtask

  // strobes stay up between calls so back-to-back cycles need no gap
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge CLOCK_IN);
    ADDR_IN <= a;
    WR_DATA_IN <= d;
    WR_STB_IN <= w;
    RD_STB_IN <= !w;
  endtask

  task automatic idle;
    @(posedge CLOCK_IN);
    WR_STB_IN <= 1'b0;
    RD_STB_IN <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
    idle;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] want);
    bus(1'b0, a, 32'h0);
    idle;
    #1 check(RD_DATA_OUT, want);
  endtask

  task automatic ticks(input int n);
    repeat (n) @(posedge CLOCK_IN iff TICK_IN);
  endtask

  // outputs are registered one clock behind the tick edge
  task automatic settle;
    repeat (2) @(posedge CLOCK_IN);
    #1;
  endtask

  task automatic regs;
    rd(`ADDR_MODE, 32'h1);
    rd(8'h40, 32'h0);
    bus(1'b1, `ADDR_HOLD, 32'hA5);
    bus(1'b0, `ADDR_HOLD, 32'h0);
    idle;
    #1 check(RD_DATA_OUT, 32'hA5);
    wr(`ADDR_HOLD, 32'h0);
  endtask

  task automatic timers;
    for (int c = 0; c < 8; c++) begin
      if (c < 5) wr({`GRP_CFG, c[2:0]}, c);
      wr({`GRP_PARAM_A, c[2:0]}, 32'h3);
    end
    wr(`ADDR_HOLD, 32'h60);
    wr(`ADDR_PANEL, 32'h20);
    ticks(1);
    repeat (2) @(posedge CLOCK_IN);
    for (int i = 0; i < 12; i++) begin
      @(posedge CLOCK_IN);
      for (int c = 0; c < 8; c++) begin
        LOGIC_IN[c] <= tin_tab[c][i];
        RESET_CH_IN[c] <= rst_tab[c][i];
      end
      ticks(1);
      settle;
      for (int c = 0; c < 8; c++)
        check(LOGIC_OUT[c], exp_tab[c][i]);
    end
  endtask

  task automatic totals;
    wr(`ADDR_HOLD, 32'h0);
    wr(`ADDR_MODE, 32'h2);
    wr({`GRP_CFG, 3'h1}, 32'h8);
    wr({`GRP_CFG, 3'h2}, 32'h0);
    wr({`GRP_CFG, 3'h3}, 32'h2);
    wr({`GRP_CFG, 3'h4}, 32'h1);
    for (int c = 0; c < 5; c++) begin
      wr({`GRP_PARAM_A, c[2:0]}, (c >= 2) ? 32'h64 : 32'h4);
      wr({`GRP_PARAM_B, c[2:0]}, (c == 2) ? 32'h2 : 32'h1);
    end
    @(posedge CLOCK_IN);
    RESET_CH_IN <= 8'hFF;
    LOGIC_IN <= 8'h00;
    ANALOG_IN[4] <= 16'h0002;
    ticks(2);
    RESET_CH_IN <= 8'h00;
    repeat (6) begin
      ticks(1);
      LOGIC_IN <= 8'h0F;
      ticks(1);
      LOGIC_IN <= 8'h00;
    end
    settle;
    check(NUMERIC_OUT[0], 32'h4);
    check(LOGIC_OUT[0], 1'b1);
    check(NUMERIC_OUT[1], 32'h2);
    check(LOGIC_OUT[1], 1'b0);
    check(NUMERIC_OUT[2], 32'hC);
    check(NUMERIC_OUT[3], 32'h6);
    check(NUMERIC_OUT[4], 32'h18);
    rd({`GRP_ACC, 3'h1}, 32'h1);
    @(posedge CLOCK_IN);
    RESET_CH_IN <= 8'h01;
    ticks(1);
    settle;
    check(NUMERIC_OUT[0], 32'h0);
    check(LOGIC_OUT[0], 1'b0);
    RESET_CH_IN <= 8'h00;
  endtask

  task automatic compares;
    wr(`ADDR_MODE, 32'h4);
    wr({`GRP_CFG, 3'h1}, 32'h20);
    wr({`GRP_CFG, 3'h2}, 32'h40);
    for (int c = 0; c < 3; c++) wr({`GRP_PARAM_A, c[2:0]}, 32'h64);
    ANALOG_IN <= {{5{16'h0000}}, {3{16'h0096}}};
    SETPOINT_IN[2] <= 16'h00C8;
    ticks(2);
    settle;
    check(LOGIC_OUT[2:0], 3'h1);
    check(NUMERIC_OUT[0], 32'h32);
    check(NUMERIC_OUT[1], 32'h32);
    check(NUMERIC_OUT[2], 32'hFFFFCE);
  endtask

  task automatic staging;
    wr(`ADDR_MODE, 32'h8);
    wr(`ADDR_SEQ_CFG, 32'h2);
    wr(`ADDR_SEQ_DELAY, 32'h0);
    wr({`GRP_LOAD, 3'h0}, 32'h32);
    wr({`GRP_LOAD, 3'h1}, 32'h32);
    DEMAND_IN <= 16'h0032;
    ticks(12);
    settle;
    check(LOGIC_OUT, 8'h01);
    check(SEQ_DIFF_OUT, 32'h0);
    check(CASCADE_OUT, 32'h0);
    DEMAND_IN <= 16'h0064;
    ticks(12);
    settle;
    check(LOGIC_OUT, 8'h03);
    DISABLE_IN <= 8'h02;
    ticks(6);
    settle;
    check(LOGIC_OUT, 8'h01);
  endtask

  task automatic results;
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // ceiling is about fifty times the expected run
  always @(posedge CLOCK_IN) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fails = fails + 1;
      results;
    end
  end

  initial begin
    repeat (8) @(posedge CLOCK_IN);
    RST_IN <= 1'b0;
    regs;
    timers;
    totals;
    compares;
    staging;
    results;
  end
endmodule
